// file: core/rx_packet_decoder.sv
`timescale 1ns/1ps
// Behaviour
// - Direct, buffer and packet data modes; packet after reset.
// - Fixed or variable length packets; fixed by default.
// - Interrupt when FIFO level reaches threshold 1..32; default 32.
// - Decoder none, Manchester 1 (01=one), Manchester 2 (10=one), de-whitening.
// - De-whitening generator starts from an 8-bit seed.
// - Preamble length none or 1..4 bytes; default 2.
// - Sync length none or 1..4 bytes; default 3.
// - Sync value is 8 times sync length bits; default zero.
// - Sync match tolerates 0..3 bit errors; default 0.
// - Node filter off, node only, node or 00, node or 00 or ff.
// - Node value is an 8-bit number.
// - Fixed payload length 0..32; default 32.
// - Checksum off, CCITT or IBM CRC; default off.
// - CRC generator starts from a 16-bit seed.
// - Serial data changes on falling clock, sampled rising, MSB first.
module rx_packet_decoder (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        cfg_load,
	input  wire logic [1:0]  data_mode,
	input  wire logic        var_length,
	input  wire logic [5:0]  fifo_threshold,
	input  wire logic [1:0]  dcfree_mode,
	input  wire logic [7:0]  whiten_seed,
	input  wire logic [2:0]  preamble_bytes,
	input  wire logic [2:0]  sync_bytes,
	input  wire logic [31:0] sync_value,
	input  wire logic [1:0]  sync_tolerance,
	input  wire logic [1:0]  node_mode,
	input  wire logic [7:0]  node_value,
	input  wire logic [5:0]  payload_length,
	input  wire logic [1:0]  crc_mode,
	input  wire logic [15:0] crc_seed,
	input  wire logic        demod_clk,
	input  wire logic        demod_data,
	input  wire logic        spi_clk,
	input  wire logic        register_select_n,
	input  wire logic        fifo_select_n,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	output logic             direct_data,
	output logic             fifo_int,
	output logic             crc_error,
	output logic             packet_done,
	output logic             overflow
);

	// ----------------------------------------------------------------
	// Configuration, loaded by strobe, defaults at reset
	// ----------------------------------------------------------------
	logic [1:0]  mode_q;
	logic        varlen_q;
	logic [5:0]  thr_q;
	logic [1:0]  dcf_q;
	logic [7:0]  wseed_q;
	logic [2:0]  pre_len_q;
	logic [2:0]  sync_len_q;
	logic [31:0] sync_val_q;
	logic [1:0]  tol_q;
	logic [1:0]  node_q;
	logic [7:0]  node_val_q;
	logic [5:0]  pay_len_q;
	logic [1:0]  crc_q_mode;
	logic [15:0] crc_seed_q;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			mode_q     <= rx_decoder_pkg::RST_MODE;
			varlen_q   <= rx_decoder_pkg::RST_VARLEN;
			thr_q      <= rx_decoder_pkg::RST_THRESH;
			dcf_q      <= rx_decoder_pkg::RST_DCF;
			wseed_q    <= rx_decoder_pkg::RST_WSEED;
			pre_len_q  <= rx_decoder_pkg::RST_PRE_LEN;
			sync_len_q <= rx_decoder_pkg::RST_SYNC_LEN;
			sync_val_q <= rx_decoder_pkg::RST_SYNC_VAL;
			tol_q      <= rx_decoder_pkg::RST_SYNC_TOL;
			node_q     <= rx_decoder_pkg::RST_NODE;
			node_val_q <= rx_decoder_pkg::RST_NODE_VAL;
			pay_len_q  <= rx_decoder_pkg::RST_PAY_LEN;
			crc_q_mode <= rx_decoder_pkg::RST_CRC;
			crc_seed_q <= rx_decoder_pkg::RST_CRC_SEED;
		end else if (cfg_load) begin
			mode_q     <= data_mode;
			varlen_q   <= var_length;
			thr_q      <= fifo_threshold;
			dcf_q      <= dcfree_mode;
			wseed_q    <= whiten_seed;
			pre_len_q  <= preamble_bytes;
			sync_len_q <= sync_bytes;
			sync_val_q <= sync_value;
			tol_q      <= sync_tolerance;
			node_q     <= node_mode;
			node_val_q <= node_value;
			pay_len_q  <= payload_length;
			crc_q_mode <= crc_mode;
			crc_seed_q <= crc_seed;
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [5:0] meta_q;
	logic [5:0] sync_q;
	logic       dclk_prev_q;
	logic       sclk_prev_q;

	always_ff @(posedge core_clk) begin
		meta_q <= {demod_clk, demod_data, spi_clk, register_select_n, fifo_select_n, sda_in};
		sync_q <= meta_q;
	end

	wire dclk_s  = sync_q[5];
	wire ddat_s  = sync_q[4];
	wire sclk_s  = sync_q[3];
	wire rsel_n  = sync_q[2];
	wire fsel_n  = sync_q[1];

	always_ff @(posedge core_clk) begin
		if (reset) begin
			dclk_prev_q <= 1'b0;
			sclk_prev_q <= 1'b0;
		end else begin
			dclk_prev_q <= dclk_s;
			sclk_prev_q <= sclk_s;
		end
	end

	wire chip_v    = dclk_s && !dclk_prev_q;
	wire sclk_rise = sclk_s && !sclk_prev_q;
	wire sclk_fall = !sclk_s && sclk_prev_q;

	// ----------------------------------------------------------------
	// Preamble and sync word search
	// ----------------------------------------------------------------
	function automatic logic [5:0] ones(input logic [31:0] v);
		logic [5:0] n;
		n = '0;
		for (int i = 0; i < 32; i++) n = n + 6'(v[i]);
		return n;
	endfunction : ones

	rx_decoder_pkg::rx_state_e state_q;
	rx_decoder_pkg::rx_state_e state_d;
	logic [31:0] shreg_q;
	logic [5:0]  run_q;
	logic        last_chip_q;

	wire        pkt_en    = (mode_q == rx_decoder_pkg::MODE_PACKET)
	                     || (mode_q == rx_decoder_pkg::MODE_BUFFER);
	wire [5:0]  pre_bits  = {pre_len_q, 3'h0};
	wire [31:0] sync_mask = (sync_len_q >= 3'h4) ? 32'hffff_ffff
	                      : ~(32'hffff_ffff << {sync_len_q[1:0], 3'h0});
	wire [31:0] sync_diff = ({shreg_q[30:0], ddat_s} ^ sync_val_q) & sync_mask;
	wire [5:0]  sync_err  = ones(sync_diff);
	wire        sync_hit  = (sync_err <= {4'h0, tol_q});
	wire        pre_hit   = (run_q >= pre_bits);
	wire        no_sync   = (sync_len_q == 3'h0);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			shreg_q     <= '0;
			run_q       <= '0;
			last_chip_q <= 1'b0;
		end else if (chip_v) begin
			shreg_q     <= {shreg_q[30:0], ddat_s};
			last_chip_q <= ddat_s;
			if (state_q != rx_decoder_pkg::S_PRE && state_q != rx_decoder_pkg::S_SYNC)
				run_q <= '0;
			else if (ddat_s != last_chip_q && run_q != 6'h3f)
				run_q <= run_q + 6'h1;
			else
				run_q <= 6'h1;
		end
	end

	// ----------------------------------------------------------------
	// Chip decoding: Manchester or de-whitening
	// ----------------------------------------------------------------
	logic       half_q;
	logic       first_q;
	logic [7:0] lfsr_q;
	logic       enter_data;
	wire        in_body  = (state_q == rx_decoder_pkg::S_LEN) || (state_q == rx_decoder_pkg::S_NODE)
	                    || (state_q == rx_decoder_pkg::S_DATA) || (state_q == rx_decoder_pkg::S_CRC);
	wire        is_man   = (dcf_q == rx_decoder_pkg::DCF_MAN1) || (dcf_q == rx_decoder_pkg::DCF_MAN2);
	wire        man_ok   = half_q && (first_q != ddat_s);
	wire        man_bit  = (dcf_q == rx_decoder_pkg::DCF_MAN1) ? ddat_s : first_q;
	wire        wht_bit  = ddat_s ^ lfsr_q[7];
	wire        dbit_v   = chip_v && in_body && (!is_man || man_ok);
	wire        dbit     = is_man ? man_bit
	                     : (dcf_q == rx_decoder_pkg::DCF_WHITEN) ? wht_bit : ddat_s;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			half_q  <= 1'b0;
			first_q <= 1'b0;
			lfsr_q  <= '0;
		end else if (enter_data) begin
			half_q  <= 1'b0;
			lfsr_q  <= wseed_q;
		end else if (chip_v && in_body) begin
			half_q  <= !half_q;
			first_q <= ddat_s;
			lfsr_q  <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
		end
	end

	// ----------------------------------------------------------------
	// Byte assembly and CRC
	// ----------------------------------------------------------------
	logic [7:0]  byte_q;
	logic [3:0]  nbit_q;
	logic [15:0] crc_q;
	logic [15:0] rx_crc_q;
	wire  [7:0]  byte_new  = {byte_q[6:0], dbit};
	wire         byte_done = dbit_v && (nbit_q == rx_decoder_pkg::BITS_BYTE - 4'h1);
	wire  [15:0] poly      = (crc_q_mode == rx_decoder_pkg::CRC_IBM)
	                       ? rx_decoder_pkg::POLY_IBM : rx_decoder_pkg::POLY_CCITT;
	wire  [15:0] crc_next  = {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ dbit) ? poly : 16'h0000);

	always_ff @(posedge core_clk) begin
		if (reset || enter_data) begin
			nbit_q   <= '0;
			byte_q   <= '0;
			rx_crc_q <= '0;
			crc_q    <= reset ? 16'h0000 : crc_seed_q;
		end else if (dbit_v) begin
			byte_q <= byte_new;
			nbit_q <= byte_done ? 4'h0 : nbit_q + 4'h1;
			if (state_q == rx_decoder_pkg::S_CRC) rx_crc_q <= {rx_crc_q[14:0], dbit};
			else crc_q <= crc_next;
		end
	end

	// ----------------------------------------------------------------
	// Packet framing
	// ----------------------------------------------------------------
	logic [5:0] remain_q;
	logic [5:0] remain_d;
	logic [1:0] crc_cnt_q;
	logic       byte_pend_q;
	logic [7:0] byte_out_q;
	logic       stage_ready;
	logic       chk_q;
	logic       finish;
	logic       push_byte;

	wire        crc_on    = (crc_q_mode != rx_decoder_pkg::CRC_OFF);
	wire [5:0]  len_clip  = (byte_new > {2'h0, rx_decoder_pkg::MAX_PAYLOAD})
	                      ? rx_decoder_pkg::MAX_PAYLOAD : byte_new[5:0];
	wire        node_hit  = (byte_new == node_val_q)
	                     || (node_q != rx_decoder_pkg::NODE_ONLY && byte_new == rx_decoder_pkg::ADDR_ZERO)
	                     || (node_q == rx_decoder_pkg::NODE_OR_ALL
	                         && byte_new == rx_decoder_pkg::ADDR_BCAST);
	wire        node_on   = (node_q != rx_decoder_pkg::NODE_OFF);
	wire        buf_mode  = (mode_q == rx_decoder_pkg::MODE_BUFFER);
	wire [5:0]  rem_next  = (state_q == rx_decoder_pkg::S_SYNC) ? pay_len_q
	                      : (state_q == rx_decoder_pkg::S_LEN) ? len_clip
	                      : (state_q == rx_decoder_pkg::S_DATA) ? remain_q - 6'h1 : remain_q;
	wire rx_decoder_pkg::rx_state_e after_hdr = (rem_next == 6'h0)
	                     ? (crc_on ? rx_decoder_pkg::S_CRC : rx_decoder_pkg::S_PRE)
	                     : rx_decoder_pkg::S_DATA;

	always_comb begin
		state_d    = state_q;
		remain_d   = remain_q;
		enter_data = 1'b0;
		finish     = 1'b0;
		push_byte  = 1'b0;
		case (state_q)
			rx_decoder_pkg::S_PRE: begin
				if (pkt_en && chip_v && pre_hit) begin
					state_d = rx_decoder_pkg::S_SYNC;
				end
			end
			rx_decoder_pkg::S_SYNC: begin
				if (no_sync || (chip_v && sync_hit)) begin
					enter_data = 1'b1;
					remain_d   = pay_len_q;
					if (buf_mode) state_d = rx_decoder_pkg::S_DATA;
					else if (varlen_q) state_d = rx_decoder_pkg::S_LEN;
					else if (node_on) state_d = rx_decoder_pkg::S_NODE;
					else state_d = after_hdr;
				end
			end
			rx_decoder_pkg::S_LEN: begin
				if (byte_done) begin
					remain_d = len_clip;
					state_d  = node_on ? rx_decoder_pkg::S_NODE : after_hdr;
				end
			end
			rx_decoder_pkg::S_NODE: begin
				if (byte_done) begin
					state_d = node_hit ? after_hdr : rx_decoder_pkg::S_PRE;
				end
			end
			rx_decoder_pkg::S_DATA: begin
				if (byte_done) begin
					push_byte = 1'b1;
					if (!buf_mode) begin
						remain_d = remain_q - 6'h1;
						state_d  = after_hdr;
					end
				end
			end
			rx_decoder_pkg::S_CRC: begin
				if (byte_done && crc_cnt_q == rx_decoder_pkg::CRC_BYTES - 2'h1) begin
					state_d = rx_decoder_pkg::S_PRE;
				end
			end
			default: state_d = rx_decoder_pkg::S_PRE;
		endcase
		if (!pkt_en) state_d = rx_decoder_pkg::S_PRE;
		finish = in_body && (state_d == rx_decoder_pkg::S_PRE)
		      && !(state_q == rx_decoder_pkg::S_NODE && !node_hit);
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q   <= rx_decoder_pkg::S_PRE;
			remain_q  <= '0;
			crc_cnt_q <= '0;
		end else begin
			state_q   <= state_d;
			remain_q  <= remain_d;
			if (enter_data) crc_cnt_q <= '0;
			else if (byte_done && state_q == rx_decoder_pkg::S_CRC) crc_cnt_q <= crc_cnt_q + 2'h1;
		end
	end

	// Held byte waits for staging space; a second byte meanwhile is lost.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			byte_pend_q <= 1'b0;
			byte_out_q  <= '0;
			overflow    <= 1'b0;
		end else begin
			if (push_byte && byte_pend_q && !stage_ready) overflow <= 1'b1;
			else if (enter_data) overflow <= 1'b0;
			if (push_byte && !(byte_pend_q && !stage_ready)) begin
				byte_pend_q <= 1'b1;
				byte_out_q  <= byte_new;
			end else if (stage_ready) begin
				byte_pend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			chk_q       <= 1'b0;
			crc_error   <= 1'b0;
			packet_done <= 1'b0;
		end else begin
			chk_q       <= finish && crc_on && !buf_mode;
			packet_done <= finish;
			if (chk_q) crc_error <= (crc_q != rx_crc_q);
			else if (enter_data) crc_error <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Staging FIFO and 32-byte receive FIFO
	// ----------------------------------------------------------------
	logic [7:0] mem_q [rx_decoder_pkg::FIFO_BYTES];
	logic [4:0] wr_q;
	logic [4:0] rd_q;
	logic [5:0] count_q;
	logic       stage_valid;
	logic [7:0] stage_data;
	logic       pop_byte;
	wire        mem_room = (count_q != rx_decoder_pkg::FIFO_FULL);
	wire        mem_push = stage_valid && mem_room;

	stage_fifo #(
		.WIDTH (8),
		.DEPTH (rx_decoder_pkg::STAGE_DEPTH)
	) u_stage (
		.core_clk  (core_clk),
		.reset     (reset),
		.in_valid  (byte_pend_q),
		.in_ready  (stage_ready),
		.in_data   (byte_out_q),
		.out_valid (stage_valid),
		.out_ready (mem_room),
		.out_data  (stage_data)
	);

	always_ff @(posedge core_clk) begin
		if (mem_push) mem_q[wr_q] <= stage_data;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wr_q     <= '0;
			rd_q     <= '0;
			count_q  <= '0;
			fifo_int <= 1'b0;
		end else begin
			if (mem_push) wr_q <= wr_q + 5'h1;
			if (pop_byte) rd_q <= rd_q + 5'h1;
			count_q  <= count_q + 6'(mem_push) - 6'(pop_byte);
			fifo_int <= (count_q >= thr_q);
		end
	end

	// ----------------------------------------------------------------
	// Serial FIFO read port
	// ----------------------------------------------------------------
	logic       rd_act_q;
	logic [7:0] tx_q;
	logic [3:0] tx_cnt_q;
	wire        rd_sel   = !fsel_n && rsel_n;
	wire        rd_start = rd_sel && !rd_act_q;
	wire        reload   = rd_act_q && sclk_fall && (tx_cnt_q == rx_decoder_pkg::BITS_BYTE);
	wire [7:0]  head     = (count_q != 6'h0) ? mem_q[rd_q] : 8'h00;
	assign pop_byte = (rd_start || reload) && (count_q != 6'h0);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rd_act_q <= 1'b0;
			tx_q     <= '0;
			tx_cnt_q <= '0;
			sda_out  <= 1'b0;
			sda_oe_n <= 1'b1;
		end else begin
			rd_act_q <= rd_sel;
			sda_oe_n <= !rd_sel;
			if (rd_start || reload) begin
				tx_q     <= {head[6:0], 1'b0};
				sda_out  <= head[7];
				tx_cnt_q <= '0;
			end else if (rd_act_q && sclk_fall) begin
				sda_out <= tx_q[7];
				tx_q    <= {tx_q[6:0], 1'b0};
			end else if (rd_act_q && sclk_rise) begin
				tx_cnt_q <= tx_cnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) direct_data <= 1'b0;
		else if (chip_v) direct_data <= (mode_q == rx_decoder_pkg::MODE_DIRECT) && ddat_s;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_reset_defaults: assert property ($past(reset) && !$past(cfg_load) |-> mode_q ==
		rx_decoder_pkg::MODE_PACKET && thr_q == 6'h20 && pay_len_q == 6'h20)
		else $error("config defaults wrong after reset");
	a_direct_idle: assert property (mode_q == rx_decoder_pkg::MODE_DIRECT |=>
		state_q == rx_decoder_pkg::S_PRE)
		else $error("framer active in direct mode");
	a_int_threshold: assert property (count_q >= thr_q && $stable(count_q) |=> fifo_int)
		else $error("threshold interrupt missing");
	a_seed_loaded: assert property (enter_data |=> crc_q == $past(crc_seed_q)
		&& lfsr_q == $past(wseed_q))
		else $error("seed not loaded at sync");
	a_sync_errors: assert property (state_q == rx_decoder_pkg::S_SYNC && in_body == 1'b0
		&& chip_v && !no_sync && sync_err > {4'h0, tol_q} |=> state_q == rx_decoder_pkg::S_SYNC)
		else $error("sync accepted beyond tolerance");
	a_fixed_length: assert property (enter_data && !varlen_q |=> remain_q == $past(pay_len_q))
		else $error("fixed length not loaded");
	a_push_gated: assert property ($rose(byte_pend_q) |->
		$past(state_q) == rx_decoder_pkg::S_DATA)
		else $error("byte stored outside payload");
	a_crc_flag: assert property (chk_q |=> crc_error == $past(crc_q != rx_crc_q))
		else $error("crc flag mismatch");
	a_select_clash: assert property (!rsel_n |=> sda_oe_n)
		else $error("data driven while register select low");
	a_fifo_bound: assert property (count_q <= rx_decoder_pkg::FIFO_FULL)
		else $error("fifo level above capacity");

	c_packet_done: cover property (packet_done);
	c_crc_error: cover property (chk_q ##1 crc_error);
	c_fifo_int: cover property ($rose(fifo_int));
	c_fifo_read: cover property (reload && count_q != 6'h0);

endmodule : rx_packet_decoder

// file: shared/rx_decoder_pkg.sv
package rx_decoder_pkg;

	// ----------------------------------------------------------------
	// Mode encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_DIRECT = 2'h0;
	localparam logic [1:0] MODE_BUFFER = 2'h1;
	localparam logic [1:0] MODE_PACKET = 2'h2;

	localparam logic [1:0] DCF_NONE    = 2'h0;
	localparam logic [1:0] DCF_MAN1    = 2'h1;
	localparam logic [1:0] DCF_MAN2    = 2'h2;
	localparam logic [1:0] DCF_WHITEN  = 2'h3;

	localparam logic [1:0] NODE_OFF    = 2'h0;
	localparam logic [1:0] NODE_ONLY   = 2'h1;
	localparam logic [1:0] NODE_OR_00  = 2'h2;
	localparam logic [1:0] NODE_OR_ALL = 2'h3;

	localparam logic [1:0] CRC_OFF     = 2'h0;
	localparam logic [1:0] CRC_CCITT   = 2'h1;
	localparam logic [1:0] CRC_IBM     = 2'h2;

	localparam logic [15:0] POLY_CCITT = 16'h1021;
	localparam logic [15:0] POLY_IBM   = 16'h8005;
	localparam logic [7:0]  ADDR_ZERO  = 8'h00;
	localparam logic [7:0]  ADDR_BCAST = 8'hff;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [1:0]  RST_MODE     = MODE_PACKET;
	localparam logic        RST_VARLEN   = 1'b0;
	localparam logic [5:0]  RST_THRESH   = 6'h20;
	localparam logic [1:0]  RST_DCF      = DCF_NONE;
	localparam logic [7:0]  RST_WSEED    = 8'h00;
	localparam logic [2:0]  RST_PRE_LEN  = 3'h2;
	localparam logic [2:0]  RST_SYNC_LEN = 3'h3;
	localparam logic [31:0] RST_SYNC_VAL = 32'h0000_0000;
	localparam logic [1:0]  RST_SYNC_TOL = 2'h0;
	localparam logic [1:0]  RST_NODE     = NODE_OFF;
	localparam logic [7:0]  RST_NODE_VAL = 8'h00;
	localparam logic [5:0]  RST_PAY_LEN  = 6'h20;
	localparam logic [1:0]  RST_CRC      = CRC_OFF;
	localparam logic [15:0] RST_CRC_SEED = 16'h0000;

	// ----------------------------------------------------------------
	// Sizes and counts
	// ----------------------------------------------------------------
	localparam int          FIFO_BYTES   = 32;
	localparam logic [5:0]  FIFO_FULL    = 6'h20;
	localparam int          STAGE_DEPTH  = 4;
	localparam logic [3:0]  BITS_BYTE    = 4'h8;
	localparam logic [5:0]  MAX_PAYLOAD  = 6'h20;
	localparam logic [1:0]  CRC_BYTES    = 2'h2;

	typedef enum logic [2:0] {
		S_PRE  = 3'b000,
		S_SYNC = 3'b001,
		S_LEN  = 3'b011,
		S_NODE = 3'b010,
		S_DATA = 3'b110,
		S_CRC  = 3'b111
	} rx_state_e;

endpackage : rx_decoder_pkg

// file: core/stage_fifo.sv
`timescale 1ns/1ps
module stage_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];

	always_ff @(posedge core_clk) begin
		if (push) mem_q[wr_q] <= in_data;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
			if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : stage_fifo

// file: sim/spi_host.sv
`timescale 1ns/1ps
// ----
// FIFO reader on the serial port
// ----
module spi_host (
	input  wire logic core_clk,
	input  wire logic sda_out,
	output logic      spi_clk,
	output logic      fifo_select_n,
	output logic      register_select_n
);
	initial begin
		spi_clk = 1'b0;
		fifo_select_n = 1'b1;
		register_select_n = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : wt
	// Each select moves only while the other is high: never both low
	task automatic sel(input logic v);
		wt(1);
		fifo_select_n = v;
	endtask : sel
	task automatic reg_sel(input logic v);
		wt(1);
		register_select_n = v;
	endtask : reg_sel
	task automatic read_byte(output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			wt(8);
			spi_clk = 1'b1;
			d[i] = sda_out; // Sample on rise, MSB first
			wt(8);
			spi_clk = 1'b0;
		end
	endtask : read_byte
endmodule : spi_host

// file: sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top;
	logic        core_clk = 0, reset = 1, cfg_load = 0, var_length = 0;
	logic        demod_clk = 0, demod_data = 0, sda_in = 0;
	logic [1:0]  data_mode = rx_decoder_pkg::MODE_PACKET, dcfree_mode = 0, node_mode = 0;
	logic [1:0]  sync_tolerance = 0, crc_mode = 0;
	logic [5:0]  fifo_threshold = 6'h03, payload_length = 6'h03;
	logic [7:0]  whiten_seed = 0, node_value = 0;
	logic [2:0]  preamble_bytes = 3'h1, sync_bytes = 3'h1; // Sync never none
	logic [31:0] sync_value = 32'h0000_00a5;
	logic [15:0] crc_seed = 0;
	logic        spi_clk, register_select_n, fifo_select_n, sda_out, sda_oe_n;
	logic        direct_data, fifo_int, crc_error, packet_done, overflow;
	int          miscompares = 0, num_checks = 0, dones = 0, seed = 32'h5523428a;
	logic [7:0]  exp_q[$];
	rx_packet_decoder rx_packet_decoder_inst (.core_clk, .reset, .cfg_load, .data_mode,
		.var_length, .fifo_threshold, .dcfree_mode, .whiten_seed, .preamble_bytes,
		.sync_bytes, .sync_value, .sync_tolerance, .node_mode, .node_value,
		.payload_length, .crc_mode, .crc_seed, .demod_clk, .demod_data, .spi_clk,
		.register_select_n, .fifo_select_n, .sda_in, .sda_out, .sda_oe_n, .direct_data,
		.fifo_int, .crc_error, .packet_done, .overflow);
	spi_host spi_host_inst (.core_clk, .sda_out, .spi_clk, .fifo_select_n,
		.register_select_n);
	initial forever #20 core_clk = ~core_clk;
	always @(posedge core_clk) if (packet_done === 1'b1) dones++;
	// ----
	// Stimulus helpers
	// ----
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	// Link clock idles low between frames, 320 ns period
	task automatic chip(input logic v);
		demod_data = v;
		cyc(4);
		demod_clk = 1'b1;
		cyc(4);
		demod_clk = 1'b0;
	endtask : chip
	// Manchester sends two chips a bit
	task automatic byte_out(input logic [7:0] v, input logic [1:0] dcf = 2'h0);
		for (int i = 7; i >= 0; i--) begin
			if (dcf != 2'h0) chip(v[i] ^ (dcf == rx_decoder_pkg::DCF_MAN1));
			chip(v[i] ^ (dcf == rx_decoder_pkg::DCF_MAN2));
		end
	endtask : byte_out
	function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] v);
		for (int i = 7; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction : crc_step
	task automatic test_done;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	initial begin
		#1ms;
		miscompares++;
		test_done;
	end
	// ----
	// Main sequence
	// ----
	initial begin
		logic [7:0]  b;
		logic [7:0]  x;
		logic [15:0] c;
		cyc(20);
		reset = 0;
		`CHK("fifo_int", 1'b0, fifo_int)
		`CHK("oe_n", 1'b1, sda_oe_n)
		// Frame 0 plain, 1 bad CRC, 2 good CRC with one sync bit wrong,
		// 3 Manchester 1 variable length with node, 4 Manchester 2 node or zero
		for (int k = 0; k < 5; k++) begin
			crc_mode = k ? rx_decoder_pkg::CRC_CCITT : rx_decoder_pkg::CRC_OFF;
			crc_seed = 16'($random(seed));
			sync_tolerance = (k == 2) ? 2'h1 : 2'h0;
			dcfree_mode = (k == 3) ? rx_decoder_pkg::DCF_MAN1
				: (k == 4) ? rx_decoder_pkg::DCF_MAN2 : rx_decoder_pkg::DCF_NONE;
			var_length = (k == 3);
			node_mode = (k == 3) ? rx_decoder_pkg::NODE_ONLY
				: (k == 4) ? rx_decoder_pkg::NODE_OR_00 : rx_decoder_pkg::NODE_OFF;
			node_value = 8'($random(seed));
			cfg_load = 1;
			cyc(1);
			cfg_load = 0;
			c = crc_seed;
			dones = 0;
			byte_out(8'haa);
			byte_out(8'haa);
			byte_out(8'ha5 ^ ((k == 2) ? 8'h01 : 8'h00));
			if (k == 3) begin
				c = crc_step(c, 8'h03);
				byte_out(8'h03, dcfree_mode);
			end
			if (k > 2) begin
				b = (k == 3) ? node_value : 8'h00;
				c = crc_step(c, b);
				byte_out(b, dcfree_mode);
			end
			repeat (3) begin
				b = 8'($random(seed));
				exp_q.push_back(b);
				c = crc_step(c, b);
				byte_out(b, dcfree_mode);
			end
			c = c ^ ((k == 1) ? 16'h0100 : 16'h0000);
			if (k) byte_out(c[15:8], dcfree_mode);
			if (k) byte_out(c[7:0], dcfree_mode);
			cyc(30);
			`CHK("done", 1, dones)
			`CHK("crc_err", 1'(k == 1), crc_error)
			`CHK("fifo_int", 1'b1, fifo_int)
			`CHK("overflow", 1'b0, overflow)
			`CHK("direct", 1'b0, direct_data)
			spi_host_inst.sel(1'b0);
			cyc(6);
			`CHK("oe_n", 1'b0, sda_oe_n)
			repeat (3) begin
				spi_host_inst.read_byte(b);
				x = exp_q.pop_front();
				`CHK("byte", x, b)
			end
			spi_host_inst.sel(1'b1);
			cyc(6);
			`CHK("fifo_int", 1'b0, fifo_int)
			spi_host_inst.reg_sel(1'b0);
			cyc(6);
			`CHK("oe_n", 1'b1, sda_oe_n)
			spi_host_inst.reg_sel(1'b1);
		end
		test_done;
	end
endmodule : tb_top
